// ===== core/rts_ahb_slave.sv
`timescale 1ns/1ps
module rts_ahb_slave
  import rts_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  rts_reg_if.bus_side bus
);
  typedef struct packed {
    logic [7:0] addr;
    logic mapped;
    logic write;
    logic pending;
    logic readyout;
    logic [31:0] rdata;
  } rts_ahb_s;

  rts_ahb_s r;
  rts_ahb_s next_r;
  logic accept;

  // Only whole-word transfers are issued, so hsize is not decoded
  assign accept = hsel && htrans[1] && hready && r.readyout;
  assign bus.addr = r.addr;
  assign bus.wr_en = r.pending && r.write && r.mapped;
  assign bus.wdata = hwdata;

  always_comb begin
    next_r = r;
    if (accept) begin
      next_r.addr = haddr[7:0];
      next_r.mapped = (haddr[31:REG_ADDR_W] == 24'h000000) && (haddr[1:0] == 2'h0);
      next_r.write = hwrite;
      next_r.pending = 1'b1;
      next_r.readyout = 1'b0;
    end else if (r.pending) begin
      // One wait state so read data leaves a flop
      next_r.pending = 1'b0;
      next_r.readyout = 1'b1;
      next_r.rdata = (r.mapped && !r.write) ? bus.rdata : 32'h00000000;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '{addr: 8'h00, mapped: 1'b0, write: 1'b0, pending: 1'b0,
             readyout: 1'b1, rdata: 32'h00000000};
    end else begin
      r <= next_r;
    end
  end

  assign hreadyout = r.readyout;
  assign hrdata = r.rdata;
  assign hresp = 1'b0;

  property p_wait_one;
    @(posedge clk) disable iff (srst)
    accept |=> !hreadyout ##1 hreadyout;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("slave wait state not one cycle");
endmodule // rts_ahb_slave

// ===== core/rts_pkg.sv
package rts_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_INT_EN = 8'h00;
  localparam logic [7:0] OFF_INT_EDGE = 8'h04;
  localparam logic [7:0] OFF_CTL_EN = 8'h08;
  localparam logic [7:0] OFF_CTL_EDGE = 8'h0c;
  localparam logic [7:0] OFF_POST_LEN = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam int REG_ADDR_W = 8;
  // Reset values
  localparam logic [7:0] RST_INT_EN = 8'h03;
  localparam logic [7:0] RST_INT_EDGE = 8'h00;
  localparam logic [7:0] RST_CTL_EN = 8'h00;
  localparam logic [7:0] RST_CTL_EDGE = 8'h00;
  localparam int POST_W = 6;
  localparam logic [5:0] RST_POST_LEN = 6'h05;
  localparam logic [5:0] POST_LEN_MAX = 6'h26;
  // Status register bits
  localparam int STATUS_FULL_BIT = 0;
  localparam int STATUS_BUSY_BIT = 1;
  // Source vector layout
  localparam int N_INT = 4;
  localparam int N_CTL = 8;
  localparam int N_SRC = N_INT + N_CTL;

  typedef enum logic [1:0] {
    RTS_ARMED = 2'b00,
    RTS_POST = 2'b01,
    RTS_FULL = 2'b10
  } rts_rec_e;
endpackage

// ===== core/rts_reg_if.sv
`timescale 1ns/1ps
interface rts_reg_if;
  logic [7:0] addr;
  logic wr_en;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport bus_side (output addr, output wr_en, output wdata, input rdata);
  modport reg_side (input addr, input wr_en, input wdata, output rdata);
endinterface

// ===== core/rts_trigger_select.sv
// Design decisions made here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Contract
// - Enable bits 0,1 pick low/high-set stages
// - Bits 2,3 pick harmonic blocks; reset 3
// - Internal edge bits: set falling, clear rising
// - Control enable bits 0..4 pick external inputs
// - Bits 5..7 pick intermodular signals; reset 0
// - Control edge bits: set falling, clear rising
// - Record post length cycles, reset five
// - Status full; write zero clears, one ignored
module rts_trigger_select
  import rts_pkg::*;
#(
  parameter int POST_MAX = int'(POST_LEN_MAX)
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic low_set_stage,
  input wire logic high_set_stage,
  input wire logic second_harmonic_block,
  input wire logic fifth_harmonic_block,
  input wire logic ext_control_in_1,
  input wire logic ext_control_in_2,
  input wire logic ext_control_in_3,
  input wire logic ext_control_in_4,
  input wire logic ext_control_in_5,
  input wire logic intermodule_ctrl_1,
  input wire logic intermodule_ctrl_2,
  input wire logic intermodule_ctrl_3,
  output logic record_start,
  output logic recording_active,
  output logic recording_full,
  output logic memory_clear
);
  generate
    if (POST_MAX < 1 || POST_MAX > 63) begin : g_bad_post
      $error("POST_MAX must fit the six-bit length field");
    end
  endgenerate

  typedef struct packed {
    logic [7:0] int_en;
    logic [7:0] int_edge;
    logic [7:0] ctl_en;
    logic [7:0] ctl_edge;
    logic [POST_W-1:0] post_len;
    logic [N_CTL-1:0] ctl_meta;
    logic [N_CTL-1:0] ctl_sync;
    logic [N_SRC-1:0] src_prev;
    logic primed;
    rts_rec_e rec;
    logic [POST_W-1:0] post_cnt;
    logic record_start;
    logic recording_active;
    logic recording_full;
    logic memory_clear;
  } rts_main_s;

  rts_main_s r;
  rts_main_s next_r;
  rts_reg_if bus ();

  logic [N_INT-1:0] int_in;
  logic [N_CTL-1:0] ctl_in;
  logic [N_SRC-1:0] src_cur;
  logic [N_SRC-1:0] src_en;
  logic [N_SRC-1:0] src_fall_sel;
  logic [N_SRC-1:0] src_hit;
  logic trig;
  logic wr_status;
  logic clr;

  rts_ahb_slave u_slave (
    .clk(clk),
    .srst(srst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .bus(bus.bus_side)
  );

  // Protection stages share this clock; control inputs come from pins
  assign int_in = {fifth_harmonic_block, second_harmonic_block, high_set_stage,
                   low_set_stage};
  assign ctl_in = {intermodule_ctrl_3, intermodule_ctrl_2, intermodule_ctrl_1,
                   ext_control_in_5, ext_control_in_4, ext_control_in_3,
                   ext_control_in_2, ext_control_in_1};
  assign src_cur = {r.ctl_sync, int_in};
  assign src_en = {r.ctl_en, r.int_en[N_INT-1:0]};
  assign src_fall_sel = {r.ctl_edge, r.int_edge[N_INT-1:0]};

  genvar gi;
  generate
    for (gi = 0; gi < N_SRC; gi++) begin : g_edge
      assign src_hit[gi] = src_en[gi] && (src_fall_sel[gi] ?
                           (r.src_prev[gi] && !src_cur[gi]) :
                           (!r.src_prev[gi] && src_cur[gi]));
    end
  endgenerate

  // Upper internal enable bits are stored but select nothing
  assign trig = r.primed && (|src_hit);
  assign wr_status = bus.wr_en && (bus.addr == OFF_STATUS);
  assign clr = wr_status && !bus.wdata[0];

  always_comb begin
    case (bus.addr)
      OFF_INT_EN: bus.rdata = {24'h000000, r.int_en};
      OFF_INT_EDGE: bus.rdata = {24'h000000, r.int_edge};
      OFF_CTL_EN: bus.rdata = {24'h000000, r.ctl_en};
      OFF_CTL_EDGE: bus.rdata = {24'h000000, r.ctl_edge};
      OFF_POST_LEN: bus.rdata = {26'h0, r.post_len};
      OFF_STATUS: bus.rdata = {30'h0, r.recording_active,
                               r.recording_full};
      default: bus.rdata = 32'h00000000;
    endcase
  end

  always_comb begin
    next_r = r;
    next_r.ctl_meta = ctl_in;
    next_r.ctl_sync = r.ctl_meta;
    next_r.src_prev = src_cur;
    // First cycle after reset has no valid previous sample
    next_r.primed = 1'b1;
    next_r.record_start = 1'b0;
    next_r.memory_clear = 1'b0;
    if (bus.wr_en) begin
      case (bus.addr)
        OFF_INT_EN: next_r.int_en = bus.wdata[7:0];
        OFF_INT_EDGE: next_r.int_edge = bus.wdata[7:0];
        OFF_CTL_EN: next_r.ctl_en = bus.wdata[7:0];
        OFF_CTL_EDGE: next_r.ctl_edge = bus.wdata[7:0];
        OFF_POST_LEN: begin
          if (int'(bus.wdata[POST_W-1:0]) <= POST_MAX && bus.wdata[31:POST_W] == 26'h0) begin
            next_r.post_len = bus.wdata[POST_W-1:0];
          end
        end
        default: ;
      endcase
    end
    if (clr) begin
      next_r.rec = RTS_ARMED;
      next_r.recording_full = 1'b0;
      next_r.recording_active = 1'b0;
      next_r.memory_clear = 1'b1;
    end
    // A trigger in the clearing cycle still starts a fresh recording
    if ((clr || r.rec == RTS_ARMED) && trig) begin
      next_r.record_start = 1'b1;
      if (r.post_len == 6'h00) begin
        next_r.rec = RTS_FULL;
        next_r.recording_full = 1'b1;
      end else begin
        next_r.rec = RTS_POST;
        next_r.post_cnt = r.post_len;
        next_r.recording_active = 1'b1;
      end
    end else if (!clr) begin
      case (r.rec)
        RTS_ARMED: ;
        RTS_POST: begin
          next_r.post_cnt = r.post_cnt - 6'h01;
          if (r.post_cnt == 6'h01) begin
            next_r.rec = RTS_FULL;
            next_r.recording_active = 1'b0;
            next_r.recording_full = 1'b1;
          end
        end
        RTS_FULL: ;
        default: next_r.rec = RTS_ARMED;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '{int_en: RST_INT_EN, int_edge: RST_INT_EDGE, ctl_en: RST_CTL_EN,
             ctl_edge: RST_CTL_EDGE, post_len: RST_POST_LEN, ctl_meta: '0,
             ctl_sync: '0, src_prev: '0, primed: 1'b0, rec: RTS_ARMED,
             post_cnt: '0, record_start: 1'b0, recording_active: 1'b0,
             recording_full: 1'b0, memory_clear: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign record_start = r.record_start;
  assign recording_active = r.recording_active;
  assign recording_full = r.recording_full;
  assign memory_clear = r.memory_clear;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  property p_low_rise;
    r.rec == RTS_ARMED && r.primed && r.int_en[0] && !r.int_edge[0] &&
    !r.src_prev[0] && low_set_stage && !clr |=> record_start;
  endproperty
  a_low_rise: assert property (p_low_rise) else $error("low-set rise missed");

  property p_reset_vals;
    $fell(srst) |-> r.int_en == 8'h03 && r.ctl_en == 8'h00 && r.post_len == 6'h05;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad factory values");

  property p_int_fall;
    r.rec == RTS_ARMED && r.primed && r.int_en[2] && r.int_edge[2] &&
    r.src_prev[2] && !second_harmonic_block |=> record_start;
  endproperty
  a_int_fall: assert property (p_int_fall) else $error("falling edge missed");

  property p_cause;
    record_start |-> $past(|(src_en & (src_fall_sel ^ src_cur) & (src_fall_sel ^ ~r.src_prev)));
  endproperty
  a_cause: assert property (p_cause) else $error("start without enabled edge");

  property p_ctl_quiet;
    r.ctl_en == 8'h00 && r.int_en[3:0] == 4'h0 |=> !record_start;
  endproperty
  a_ctl_quiet: assert property (p_ctl_quiet) else $error("start with all disabled");

  property p_ctl_fall;
    r.rec == RTS_ARMED && r.primed && r.ctl_en[7] && r.ctl_edge[7] &&
    r.src_prev[11] && !r.ctl_sync[7] |=> record_start;
  endproperty
  a_ctl_fall: assert property (p_ctl_fall) else $error("control fall missed");

  property p_post_five;
    record_start && recording_active && r.post_cnt == 6'h05 && !clr
    ##1 !clr[*4] |-> recording_active ##1 recording_full;
  endproperty
  a_post_five: assert property (p_post_five) else $error("post length wrong");

  property p_clear;
    clr |=> memory_clear ##0 (!recording_full || record_start);
  endproperty
  a_clear: assert property (p_clear) else $error("status clear failed");

  property p_nop;
    recording_full && wr_status && bus.wdata[0] |=> recording_full && !memory_clear;
  endproperty
  a_nop: assert property (p_nop) else $error("write one changed status");

  property p_edge_sample;
    r.primed |-> r.src_prev[N_INT-1:0] == $past(int_in);
  endproperty
  a_edge_sample: assert property (p_edge_sample) else $error("previous sample stale");
endmodule // rts_trigger_select

// ===== dv/recorder_trigger_select_tb_top.sv
`timescale 1ns/1ps
module recorder_trigger_select_tb_top;
  import rts_pkg::*;
  logic clk = 0, srst = 1, hsel = 0, hwrite = 0, slow = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = '0;
  logic [11:0] want = '0, src;
  logic hreadyout, hresp, record_start, recording_active, recording_full, memory_clear;
  logic rd_pend = 0, full_q = 0;
  logic [31:0] exp_rd[$];
  int exp_lat[$], exp_len[$];
  int fails = 0, n_checks = 0, n_clr = 0, n_clr_exp = 0, act_cnt = 0, cyc = 0;
  integer seed = 85011;
  time t_stim = 0;
  logic [7:0] offs[7] = '{OFF_INT_EN, OFF_INT_EDGE, OFF_CTL_EN, OFF_CTL_EDGE, OFF_POST_LEN,
    OFF_STATUS, 8'h18};
  logic [31:0] rstv[7] = '{32'h3, 32'h0, 32'h0, 32'h0, 32'h5, 32'h0, 32'h0};

  always #20 clk = ~clk;

  rts_src_model i_rts_src_model (.clk(clk), .srst(srst), .want(want), .slow(slow), .src(src));

  rts_trigger_select i_rts_trigger_select (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .low_set_stage(src[0]),
    .high_set_stage(src[1]), .second_harmonic_block(src[2]), .fifth_harmonic_block(src[3]),
    .ext_control_in_1(src[4]), .ext_control_in_2(src[5]), .ext_control_in_3(src[6]),
    .ext_control_in_4(src[7]), .ext_control_in_5(src[8]), .intermodule_ctrl_1(src[9]),
    .intermodule_ctrl_2(src[10]), .intermodule_ctrl_3(src[11]), .record_start(record_start),
    .recording_active(recording_active), .recording_full(recording_full),
    .memory_clear(memory_clear));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task finish_test();
    $display("Checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Single word transfer; hready is sampled at each edge before anything moves
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] exp);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    if (!wr) exp_rd.push_back(exp);
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask

  task automatic drv(input int i, input logic v);
    logic [11:0] w;
    w = 12'($random(seed));
    w[i] = v;
    want <= w;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc > 6000) begin
      fails++;
      finish_test();
    end
    if (!srst) begin
      if (rd_pend && hreadyout) begin
        chk(hrdata, exp_rd.pop_front());
        chk(hresp, 32'h0);
        rd_pend = 0;
      end
      if (hsel && htrans == 2'h2 && hreadyout && !hwrite) rd_pend = 1;
      if (record_start) begin
        if (exp_lat.size() == 0) chk(32'h1, 32'h0);
        else chk(32'(($time - t_stim) / 40), exp_lat.pop_front());
      end
      if (recording_active) act_cnt++;
      if (recording_full && !full_q) begin
        if (exp_len.size() == 0) chk(32'h1, 32'h0);
        else chk(act_cnt, exp_len.pop_front());
        act_cnt = 0;
      end
      if (memory_clear) n_clr++;
      full_q = recording_full;
    end
  end

  initial begin
    int i, pl;
    logic fall;
    logic [31:0] r;
    logic [7:0] ie, ce;
    repeat (6) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    ahb(1, 8'h18, $random(seed), 0);
    for (int k = 0; k < 7; k++) ahb(0, offs[k], 0, rstv[k]);
    // Out-of-range length must leave the stored value alone
    ahb(1, OFF_POST_LEN, 32'h27, 0);
    ahb(0, OFF_POST_LEN, 0, 32'h5);
    for (int k = 0; k < 24; k++) begin
      i = k / 2;
      fall = k[0];
      r = $random(seed);
      pl = (k == 1) ? 38 : (k * 7) % 39;
      ie = (i < 4) ? {r[7:4], 4'h1 << i} : {r[7:4], 4'h0};
      ce = (i < 4) ? 8'h0 : 8'h1 << (i - 4);
      ahb(1, OFF_INT_EN, 0, 0);
      ahb(1, OFF_CTL_EN, 0, 0);
      drv(i, !fall);
      repeat (4) @(posedge clk);
      ahb(1, OFF_STATUS, {r[31:1], 1'b0}, 0);
      n_clr_exp++;
      ahb(1, OFF_INT_EDGE, {r[31:8], (i < 4) ? {r[15:12], {3'h0, fall} << i} : r[15:8]}, 0);
      ahb(1, OFF_CTL_EDGE, {r[31:8], (i < 4) ? r[23:16] : {7'h0, fall} << (i - 4)}, 0);
      ahb(1, OFF_POST_LEN, pl, 0);
      ahb(1, OFF_INT_EN, {r[31:8], ie}, 0);
      ahb(1, OFF_CTL_EN, {r[31:8], ce}, 0);
      ahb(0, OFF_INT_EN, 0, {24'h0, ie});
      ahb(0, OFF_CTL_EN, 0, {24'h0, ce});
      slow <= r[8];
      // Wrong direction first: nothing may start
      drv(i, fall);
      repeat (8) @(posedge clk);
      drv(i, !fall);
      t_stim = $time;
      exp_lat.push_back(((i < 4) ? 3 : 5) + int'(r[8]));
      exp_len.push_back(pl);
      repeat (pl + 10) @(posedge clk);
      ahb(1, OFF_STATUS, 32'h1, 0);
      ahb(0, OFF_STATUS, 0, 32'h1);
    end
    // Quiet sources first: the model also resets, so a live level would look like an edge
    want <= '0;
    srst <= 1;
    repeat (2) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    for (int k = 0; k < 7; k++) ahb(0, offs[k], 0, rstv[k]);
    repeat (3) @(posedge clk);
    chk(n_clr, n_clr_exp);
    chk(exp_lat.size(), 0);
    finish_test();
  end
endmodule // recorder_trigger_select_tb_top

// ===== dv/rts_src_model.sv
`timescale 1ns/1ps
module rts_src_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic [11:0] want,
  input wire logic slow,
  output logic [11:0] src
);
  logic [11:0] s1, s2;
  // Slow mode adds one stage, like a late protection output
  always_ff @(posedge clk) begin
    if (srst) begin
      s1 <= '0;
      s2 <= '0;
    end else begin
      s1 <= want;
      s2 <= s1;
    end
  end
  assign src = slow ? s2 : s1;
endmodule // rts_src_model
